// [design/isf_params.svh]
/*
  Constants of the two-wire status flag block: register offsets, flag bit
  positions, control and count bit positions, flag reset value and SMBus mask.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

`define ISF_OFF_STATUS 8'h18
`define ISF_OFF_CLEAR 8'h1c
`define ISF_OFF_CTRL 8'h00
`define ISF_OFF_COUNT 8'h04
`define ISF_OFF_RXDATA 8'h24
`define ISF_OFF_TXDATA 8'h28

`define ISF_B_ALARM 13
`define ISF_B_TLIM 12
`define ISF_B_PEC 11
`define ISF_B_OVERRUN 10
`define ISF_B_ARB 9
`define ISF_B_BUSERR 8
`define ISF_B_CCD 7
`define ISF_B_TDONE 6
`define ISF_B_STOP 5
`define ISF_B_NACK 4
`define ISF_B_MATCH 3
`define ISF_B_RXF 2
`define ISF_B_TXREQ 1
`define ISF_B_TXEMPTY 0

`define ISF_C_EN 0
`define ISF_C_TXIRQ 1
`define ISF_C_HOLDDIS 17
`define ISF_C_BYTECTL 16
`define ISF_C_TXDMA 14
`define ISF_C_ALARMEN 22
`define ISF_C_HOSTCFG 20

`define ISF_N_START 13
`define ISF_N_STOP 14
`define ISF_N_LSB 16
`define ISF_N_MSB 23
`define ISF_N_RELOAD 24
`define ISF_N_AUTO 25

`define ISF_FLAGS_RESET 14'h0001
`define ISF_SMBUS_MASK 14'h3800

`endif

// [design/isf_pkg.sv]
/*
  Types of the two-wire status flag block.
  Assumes the params header is on the include path.
*/
`include "isf_params.svh"
package isf_pkg;
  typedef struct packed {
    logic alarm_fall;
    logic time_limit;
    logic pec_mismatch;
    logic overrun;
    logic arb_lost;
    logic misplaced_cond;
    logic addr_phase;
    logic count_moved;
    logic stop_cond;
    logic stop_by_self;
    logic nack_rx;
    logic addr_match;
    logic rx_byte;
    logic tx_need;
    logic target_mode;
  } isf_bus_ev_t;
  typedef enum logic [1:0] {isf_idle, isf_rdata, isf_bresp} isf_bus_state_t;
endpackage

// [design/isf_top.sv]
/*
  Interrupt status flags of a two-wire bus controller/target, with an
  AXI4-Lite slave for the status, clear, control, count and data registers.
  Assumes bus engine events arrive as one-cycle pulses on core_clk.
*/
// Contract
// - alarm flag on enabled alarm pin fall, only with host configuration set
// - time limit flag on any timeout
// - packet check error flag, then auto NACK
// - no SMBus: three bits read zero
// - overrun flag only target, holding disabled
// - arbitration lost flag until cleared
// - bus error, not in target address
// - count continue done; cleared by count write of nonzero byte count
// - transfer done; cleared by start/stop
// - stop seen only when involved
// - not acknowledge flag on NACK
// - own match flag on address match
// - rx full set on byte, read clears
// - tx request set when empty, write clears
// - software forces tx request when holding disabled
// - tx empty; write one flushes
// - disabled forces tx empty high
// - disabled holds other flags zero
// - clear one clears; match clear drops start
`include "isf_params.svh"
module isf_top #(
  parameter bit HAS_SMBUS = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire isf_pkg::isf_bus_ev_t bus_ev,
  input wire logic [7:0] rx_byte_data,
  output logic nack_pec,
  output logic tx_event_irq,
  output logic tx_dma_req,
  output logic [7:0] tx_byte_data,
  output logic start_req,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import isf_pkg::*;

  logic [13:0] flags_reg, flags_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] count_reg, count_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] tx_reg, tx_next;
  logic nack_reg, nack_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rresp_reg, rresp_next, bresp_reg, bresp_next;
  isf_bus_state_t rst_reg, rst_next, wst_reg, wst_next;
  logic wr_do, rd_do;
  logic [31:0] wmask;
  logic [13:0] clr_bits, status_view;
  logic enabled, hold_dis;

  // Byte lanes from strobes, shared by every writable register
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    if (a == `ISF_OFF_STATUS) mapped = 1'b1;
    else if (a == `ISF_OFF_CLEAR) mapped = 1'b1;
    else if (a == `ISF_OFF_CTRL) mapped = 1'b1;
    else if (a == `ISF_OFF_COUNT) mapped = 1'b1;
    else if (a == `ISF_OFF_RXDATA) mapped = 1'b1;
    else if (a == `ISF_OFF_TXDATA) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  assign enabled = ctrl_reg[`ISF_C_EN];
  assign hold_dis = ctrl_reg[`ISF_C_HOLDDIS];
  assign wr_do = aw_have_reg && w_have_reg && (wst_reg == isf_idle);
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign wmask = lane_mask(wd_reg[3:0] == 4'h0 ? 4'h0 : 4'hf) & 32'h0;

  // Write channel: address and data latched in either order
  always_comb begin
    awa_next = awa_reg;
    wd_next = wd_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    wst_next = wst_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awa_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_next = s_axi_wdata & lane_mask(s_axi_wstrb);
      w_have_next = 1'b1;
    end
    case (wst_reg)
      isf_idle: begin
        if (wr_do) begin
          wst_next = isf_bresp;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          bresp_next = mapped(awa_reg) ? 2'h0 : 2'h2;
        end
      end
      isf_bresp: begin
        if (s_axi_bready) wst_next = isf_idle;
      end
      default: wst_next = isf_idle;
    endcase
  end

  assign s_axi_awready = !aw_have_reg && (wst_reg == isf_idle);
  assign s_axi_wready = !w_have_reg && (wst_reg == isf_idle);
  assign s_axi_bvalid = (wst_reg == isf_bresp);
  assign s_axi_bresp = bresp_reg;

  // Status view: unsupported SMBus bits (alarm, time limit, packet check) read zero
  always_comb begin
    status_view = flags_reg;
    if (!HAS_SMBUS) status_view = flags_reg & ~`ISF_SMBUS_MASK;
  end

  // Read channel; reading receive data clears the full flag below
  always_comb begin
    rst_next = rst_reg;
    rd_next = rd_reg;
    rresp_next = rresp_reg;
    case (rst_reg)
      isf_idle: begin
        if (rd_do) begin
          rst_next = isf_rdata;
          rresp_next = 2'h0;
          if (s_axi_araddr == `ISF_OFF_STATUS) rd_next = {18'h0, status_view};
          else if (s_axi_araddr == `ISF_OFF_CTRL) rd_next = ctrl_reg;
          else if (s_axi_araddr == `ISF_OFF_COUNT) rd_next = count_reg;
          else if (s_axi_araddr == `ISF_OFF_RXDATA) rd_next = {24'h0, rx_reg};
          else if (s_axi_araddr == `ISF_OFF_TXDATA) rd_next = {24'h0, tx_reg};
          else if (s_axi_araddr == `ISF_OFF_CLEAR) rd_next = 32'h0;
          else begin
            rd_next = 32'h0;
            rresp_next = 2'h2;
          end
        end
      end
      isf_rdata: begin
        if (s_axi_rready) rst_next = isf_idle;
      end
      default: rst_next = isf_idle;
    endcase
  end

  assign s_axi_arready = (rst_reg == isf_idle);
  assign s_axi_rvalid = (rst_reg == isf_rdata);
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rresp_reg;

  // Flags: set beats clear, disable beats both
  always_comb begin
    logic wr_stat, wr_clr, wr_ctrl, wr_cnt, wr_tx, rd_rx, tgt;
    wr_stat = wr_do && (awa_reg == `ISF_OFF_STATUS);
    wr_clr = wr_do && (awa_reg == `ISF_OFF_CLEAR);
    wr_ctrl = wr_do && (awa_reg == `ISF_OFF_CTRL);
    wr_cnt = wr_do && (awa_reg == `ISF_OFF_COUNT);
    wr_tx = wr_do && (awa_reg == `ISF_OFF_TXDATA);
    rd_rx = rd_do && (s_axi_araddr == `ISF_OFF_RXDATA);
    tgt = bus_ev.target_mode;
    flags_next = flags_reg;
    ctrl_next = wr_ctrl ? wd_reg : ctrl_reg;
    count_next = wr_cnt ? wd_reg : count_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    nack_next = 1'b0;
    clr_bits = wr_clr ? wd_reg[13:0] : 14'h0;
    // Clear first, so a set in the same cycle wins
    flags_next = flags_next & ~(clr_bits & 14'h3f38);
    if (clr_bits[`ISF_B_MATCH]) count_next[`ISF_N_START] = 1'b0;
    if (wr_cnt && wd_reg[`ISF_N_MSB:`ISF_N_LSB] != 8'h00) begin
      flags_next[`ISF_B_CCD] = 1'b0;
    end
    if (wr_cnt && (wd_reg[`ISF_N_START] || wd_reg[`ISF_N_STOP])) begin
      flags_next[`ISF_B_TDONE] = 1'b0;
    end
    if (rd_rx) flags_next[`ISF_B_RXF] = 1'b0;
    if (wr_tx) begin
      tx_next = wd_reg[7:0];
      flags_next[`ISF_B_TXREQ] = 1'b0;
      flags_next[`ISF_B_TXEMPTY] = 1'b0;
    end
    if (wr_stat && wd_reg[`ISF_B_TXEMPTY]) flags_next[`ISF_B_TXEMPTY] = 1'b1;
    if (wr_stat && wd_reg[`ISF_B_TXREQ] && hold_dis) begin
      flags_next[`ISF_B_TXREQ] = 1'b1;
    end
    if (ctrl_reg[`ISF_C_HOSTCFG] && ctrl_reg[`ISF_C_ALARMEN] && bus_ev.alarm_fall) begin
      flags_next[`ISF_B_ALARM] = 1'b1;
    end
    if (bus_ev.time_limit) flags_next[`ISF_B_TLIM] = 1'b1;
    if (bus_ev.pec_mismatch) begin
      flags_next[`ISF_B_PEC] = 1'b1;
      nack_next = 1'b1;
    end
    if (bus_ev.overrun && tgt && hold_dis) flags_next[`ISF_B_OVERRUN] = 1'b1;
    if (bus_ev.arb_lost) flags_next[`ISF_B_ARB] = 1'b1;
    if (bus_ev.misplaced_cond && !(tgt && bus_ev.addr_phase)) begin
      flags_next[`ISF_B_BUSERR] = 1'b1;
    end
    if (bus_ev.count_moved && count_reg[`ISF_N_RELOAD]
        && (!tgt || ctrl_reg[`ISF_C_BYTECTL])) begin
      flags_next[`ISF_B_CCD] = 1'b1;
    end
    if (bus_ev.count_moved && !tgt && !count_reg[`ISF_N_RELOAD]
        && !count_reg[`ISF_N_AUTO]) begin
      flags_next[`ISF_B_TDONE] = 1'b1;
    end
    // Target side: the match flag still up means addressed this transfer
    if (bus_ev.stop_cond && ((!tgt && bus_ev.stop_by_self)
        || (tgt && flags_reg[`ISF_B_MATCH]))) begin
      flags_next[`ISF_B_STOP] = 1'b1;
    end
    if (bus_ev.nack_rx) flags_next[`ISF_B_NACK] = 1'b1;
    if (bus_ev.addr_match) flags_next[`ISF_B_MATCH] = 1'b1;
    if (bus_ev.rx_byte) begin
      rx_next = rx_byte_data;
      flags_next[`ISF_B_RXF] = 1'b1;
    end
    if (bus_ev.tx_need) begin
      flags_next[`ISF_B_TXREQ] = 1'b1;
      flags_next[`ISF_B_TXEMPTY] = 1'b1;
    end
    if (!HAS_SMBUS) flags_next = flags_next & ~`ISF_SMBUS_MASK;
    // Disable last: it overrides every event of the same cycle
    if (!enabled) begin
      flags_next = `ISF_FLAGS_RESET;
      nack_next = 1'b0;
    end
  end

  // Transmit event follows the request flag level while its enable is set
  assign tx_event_irq = flags_reg[`ISF_B_TXREQ] && ctrl_reg[`ISF_C_TXIRQ];
  assign tx_dma_req = flags_reg[`ISF_B_TXREQ] && ctrl_reg[`ISF_C_TXDMA];
  assign nack_pec = nack_reg;
  assign tx_byte_data = tx_reg;
  assign start_req = count_reg[`ISF_N_START];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_reg <= `ISF_FLAGS_RESET;
      ctrl_reg <= 32'h0;
      count_reg <= 32'h0;
      rx_reg <= 8'h0;
      tx_reg <= 8'h0;
      nack_reg <= 1'b0;
      awa_reg <= 8'h0;
      wd_reg <= 32'h0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      rd_reg <= 32'h0;
      rresp_reg <= 2'h0;
      bresp_reg <= 2'h0;
      rst_reg <= isf_idle;
      wst_reg <= isf_idle;
    end else begin
      flags_reg <= flags_next;
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      nack_reg <= nack_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      rd_reg <= rd_next;
      rresp_reg <= rresp_next;
      bresp_reg <= bresp_next;
      rst_reg <= rst_next;
      wst_reg <= wst_next;
    end
  end

  logic unused_ok;
  assign unused_ok = ^wmask;
endmodule // isf_top

// [sim/isf_engine_model.sv]
/*
  Bus engine stand-in: one-cycle event pulses plus held levels.
  Assumes the bench names the event and holds the qualifying levels.
*/
module isf_engine_model (
  input wire logic core_clk,
  input wire logic ev_go,
  input wire logic [3:0] ev_sel,
  input wire logic [14:0] ev_lvl,
  output isf_pkg::isf_bus_ev_t bus_ev
);
  import isf_pkg::*;
  logic [14:0] pulse_reg;
  logic [14:0] pulse_next;
  always_comb begin
    pulse_next = ev_go ? 15'h0001 << ev_sel : 15'h0000;
  end
  always_ff @(posedge core_clk) begin
    pulse_reg <= pulse_next;
  end
  // Levels must ride with the pulse, the engine qualifies in that cycle
  assign bus_ev = isf_bus_ev_t'(pulse_reg | ev_lvl);
endmodule // isf_engine_model

// [sim/isf_props.sv]
/*
  Port checker of the status flag block.
  Assumes it is bound into the top module by the statement below.
*/
module isf_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire isf_pkg::isf_bus_ev_t bus_ev,
  input wire logic nack_pec,
  input wire logic tx_event_irq,
  input wire logic tx_dma_req,
  input wire logic start_req,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  import isf_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  a_pec_nack: assert property (bus_ev.pec_mismatch |=> nack_pec)
    else $error("no auto nack after pec error");
  a_nack_cause: assert property (nack_pec |-> $past(bus_ev.pec_mismatch))
    else $error("auto nack without pec error");
  a_tx_quiet: assert property ($fell(sys_rst) |-> !tx_event_irq && !tx_dma_req)
    else $error("tx event out of reset");
  a_start_drop: assert property (wr_go && s_axi_awaddr == 8'h1c && s_axi_wdata[3]
    |-> ##2 !start_req)
    else $error("match clear kept start");
  a_start_set: assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wdata[13]
    |-> ##2 start_req)
    else $error("start not taken");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_b_time: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("late write response");
  a_r_time: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read response");
  a_r_unmapped: assert property (rd_go && s_axi_araddr == 8'h3c |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  c_nack: cover property (nack_pec);
  c_clear: cover property (wr_go && s_axi_awaddr == 8'h1c);
  c_tx_ev: cover property (tx_event_irq && tx_dma_req);
endmodule // isf_props

bind isf_top isf_props u_props (.*);

// [sim/isf_top_bench.sv]
/*
  Register level bench of the status flag block.
  Assumes the engine model stands in for the two-wire bus engine.
*/
module isf_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import isf_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  isf_bus_ev_t bus_ev;
  logic [7:0] rx_byte_data = 8'h00;
  logic nack_pec, tx_event_irq, tx_dma_req, start_req;
  logic [7:0] tx_byte_data;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdv;
  logic ev_go = 1'b0;
  logic [3:0] ev_sel = 4'h0;
  logic [14:0] ev_lvl = 15'h0;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int evs[6] = '{13, 12, 10, 9, 4, 3};
  int sbs[6] = '{12, 11, 9, 8, 4, 3};

  isf_top DUT (.*);
  isf_engine_model u_engine (.*);

  always #20 core_clk = ~core_clk;

  task test_done;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang ends as a failure
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h, want %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task fire(input int n);
    @(posedge core_clk);
    ev_sel <= 4'(n);
    ev_go <= 1'b1;
    @(posedge core_clk);
    ev_go <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task st(input logic [31:0] e);
    rd(8'h18);
    chk(rdv, e);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    st(32'h1);
    fire(10);
    st(32'h1);
    $display("test disabled done");
    wr(8'h00, 32'h1);
    for (int i = 0; i < 6; i++) begin
      fire(evs[i]);
      wr(8'h1c, 32'h0);
      st(32'h1 | (32'h1 << sbs[i]));
      wr(8'h1c, 32'h1 << sbs[i]);
      st(32'h1);
    end
    $display("test set and clear done");
    fire(14);
    st(32'h1);
    wr(8'h00, 32'h500001);
    fire(14);
    st(32'h2001);
    wr(8'h1c, 32'h2000);
    wr(8'h00, 32'h20001);
    fire(11);
    st(32'h1);
    ev_lvl <= 15'h0001;
    fire(11);
    st(32'h401);
    wr(8'h1c, 32'h400);
    ev_lvl <= 15'h0101;
    fire(9);
    st(32'h1);
    ev_lvl <= 15'h0000;
    fire(6);
    st(32'h1);
    ev_lvl <= 15'h0020;
    fire(6);
    st(32'h21);
    wr(8'h1c, 32'h20);
    ev_lvl <= 15'h0001;
    fire(6);
    st(32'h1);
    fire(3);
    fire(6);
    st(32'h29);
    wr(8'h1c, 32'h28);
    ev_lvl <= 15'h0000;
    $display("test qualified flags done");
    wr(8'h04, 32'h30000);
    fire(7);
    st(32'h41);
    wr(8'h04, 32'h32000);
    st(32'h1);
    chk({31'h0, start_req}, 32'h1);
    wr(8'h1c, 32'h8);
    chk({31'h0, start_req}, 32'h0);
    wr(8'h04, 32'h1030000);
    fire(7);
    st(32'h81);
    wr(8'h04, 32'h1020000);
    st(32'h1);
    $display("test count flags done");
    rx_byte_data <= 8'ha5;
    fire(2);
    st(32'h5);
    rd(8'h24);
    chk(rdv, 32'ha5);
    st(32'h1);
    fire(1);
    st(32'h3);
    wr(8'h28, 32'h5a);
    st(32'h0);
    chk({24'h0, tx_byte_data}, 32'h5a);
    wr(8'h18, 32'h1);
    st(32'h1);
    $display("test data flags done");
    // Forcing is refused while clock holding is allowed
    wr(8'h00, 32'h4003);
    wr(8'h18, 32'h2);
    st(32'h1);
    wr(8'h00, 32'h24003);
    wr(8'h18, 32'h2);
    st(32'h3);
    chk({30'h0, tx_event_irq, tx_dma_req}, 32'h3);
    wr(8'h00, 32'h0);
    st(32'h1);
    rd(8'h3c);
    chk({30'h0, rsp}, 32'h2);
    $display("test force and disable done");
    test_done();
  end
endmodule // isf_top_bench
